// ### hdl/usb_tx_pkg.sv
// Function
// - Token sets frame-valid, artificial frame clears it
// - Any-frame flag set by every frame start
// - Frame pin low eight clocks unless disabled
// - Any-frame flag with enable raises interrupt request
// - Read-only frame timer locked status bit
// - Store 11-bit frame number from real tokens
// - Seven-bit function address, hardware reads only
// - Four FIFOs chosen by endpoint select
// - Two-set circular FIFO, overwrite protected, retransmit
// - Pointers increment per byte, marker at set
// - Good advances marker, bad reverses read pointer
// - Endpoint one ten-bit count, others five-bit
// - Count index starts set zero, toggles on write
// - Index bits show written sets, full ignores writes
// - Count write fills next free data set
// - Acknowledge clears set bit, isochronous at frame
// - Manual mode or no outcome leaves set bits unchanged
// - Auto non-isochronous: ack advances, error reverses
// - Auto isochronous always advances, clears at frame
// - Write-only data port stores byte at pointer
// - Ack and error exclusive, isochronous at frame
// - Manual advance and reverse ignored in auto
package usb_tx_pkg;
	localparam logic [7:0] FUNCTION_ADDRESS_ADDR = 8'h8F;
	localparam logic [7:0] FRAME_NUMBER_LOW_ADDR = 8'hD2;
	localparam logic [7:0] FRAME_STATUS_HIGH_ADDR = 8'hD3;
	localparam logic [7:0] TX_FIFO_DATA_PORT_ADDR = 8'hF3;
	localparam logic [7:0] TX_COUNT_LOW_ADDR = 8'hF6;
	localparam logic [7:0] TX_COUNT_HIGH_ADDR = 8'hF7;
	localparam int TOKEN_VALID_BIT = 7;
	localparam int ANY_FRAME_BIT = 6;
	localparam int IRQ_ENABLE_BIT = 5;
	localparam int TIMER_LOCKED_BIT = 4;
	localparam int PIN_DISABLE_BIT = 3;
	localparam logic [6:0] FUNCTION_ADDRESS_RESET = 7'h00;
	localparam logic [10:0] FRAME_NUMBER_RESET = 11'h000;
	localparam logic [9:0] PTR_RESET = 10'h000;
	localparam logic [9:0] COUNT_RESET = 10'h000;
	localparam logic [1:0] BIG_ENDPOINT = 2'h1;
	localparam logic [9:0] BIG_PTR_MASK = 10'h3FF;
	localparam logic [9:0] SMALL_PTR_MASK = 10'h01F;
	localparam logic [1:0] SETS_EMPTY = 2'h0;
	localparam logic [1:0] SETS_FULL = 2'h3;
	localparam logic [3:0] FRAME_PIN_CYCLES = 4'h8;

	// Index bits after a count write
	function automatic logic [1:0] fill_next_set(input logic [1:0] sets);
		fill_next_set = (sets == SETS_EMPTY) ? 2'h1 : SETS_FULL;
	endfunction : fill_next_set

	// Pointer step with wrap for the endpoint size
	function automatic logic [9:0] ptr_step(input logic [9:0] ptr, input logic [9:0] mask);
		ptr_step = (ptr + 10'h001) & mask;
	endfunction : ptr_step
endpackage : usb_tx_pkg

// ### hdl/tx_byte_ram.sv
`timescale 1ns/1ps
`default_nettype none
module tx_byte_ram
(
	// Clock
	input wire logic clk_in,
	// Write side
	input wire logic wr_en_in,
	input wire logic [11:0] wr_addr_in,
	input wire logic [7:0] wr_data_in,
	// Read side
	input wire logic [11:0] rd_addr_in,
	output logic [7:0] rd_data_out
);
	logic [7:0] mem [0:4095];

	// No reset: stored bytes are undefined until written
	always_ff @(posedge clk_in)
	begin
		if (wr_en_in)
		begin
			mem[wr_addr_in] <= wr_data_in;
		end
		rd_data_out <= mem[rd_addr_in];
	end
endmodule : tx_byte_ram
`default_nettype wire

// ### hdl/frame_pin_stretch.sv
`timescale 1ns/1ps
`default_nettype none
module frame_pin_stretch
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Control
	input wire logic trigger_in,
	input wire logic flag_in,
	input wire logic disable_in,
	// Pin
	output logic frame_pin_n_out
);
	logic [3:0] left;
	logic [3:0] next_left;
	logic next_pin_n;

	always_comb
	begin
		next_left = left;
		if (trigger_in)
		begin
			next_left = usb_tx_pkg::FRAME_PIN_CYCLES;
		end
		else if (left != 4'h0)
		begin
			next_left = left - 4'h1;
		end
		next_pin_n = 1'b1;
		if (!disable_in && next_left != 4'h0)
		begin
			next_pin_n = ~(flag_in | trigger_in);
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			left <= 4'h0;
			frame_pin_n_out <= 1'b1;
		end
		else
		begin
			left <= next_left;
			frame_pin_n_out <= next_pin_n;
		end
	end
endmodule : frame_pin_stretch
`default_nettype wire

// ### hdl/usb_fn_tx_fifo_frame_status.sv
`timescale 1ns/1ps
`default_nettype none
module usb_fn_tx_fifo_frame_status
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Special-function register access
	input wire logic [7:0] sfr_addr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic sfr_wr_in,
	input wire logic sfr_rd_in,
	output logic [7:0] sfr_rdata_out,
	// FIFO control from elsewhere in the core
	input wire logic [1:0] endpoint_select_in,
	input wire logic [3:0] tx_isochronous_flag_in,
	input wire logic [3:0] auto_tx_management_in,
	input wire logic marker_advance_ctl_in,
	input wire logic pointer_reverse_ctl_in,
	// Serial engine side
	input wire logic [1:0] sie_endpoint_in,
	input wire logic sie_rd_in,
	output logic [7:0] sie_rd_data_out,
	output logic [9:0] tx_byte_count_out,
	input wire logic sie_done_in,
	input wire logic tx_ack_in,
	input wire logic tx_err_in,
	output logic [3:0] tx_acknowledged_out,
	output logic [3:0] tx_error_flag_out,
	output logic [7:0] tx_set_index_bits_out,
	// Frame timing
	input wire logic sof_token_in,
	input wire logic [10:0] sof_frame_number_in,
	input wire logic artificial_sof_in,
	input wire logic frame_timer_locked_in,
	output logic frame_irq_out,
	output logic frame_pin_n_out,
	output logic [6:0] function_address_out
);
	logic [9:0] wr_ptr [4], rd_ptr [4], rd_mark [4];
	logic [9:0] cnt [4][2];
	logic [1:0] sets [4];
	logic rw_idx [4], rd_set [4], iso_pend [4], iso_ack [4], iso_err [4];
	logic [9:0] next_wr_ptr [4], next_rd_ptr [4], next_rd_mark [4];
	logic [9:0] next_cnt [4][2];
	logic [1:0] next_sets [4];
	logic next_rw_idx [4], next_rd_set [4], next_iso_pend [4];
	logic next_iso_ack [4], next_iso_err [4];
	logic [3:0] next_ack, next_err;
	logic token_valid, any_frame, irq_enable, pin_disable;
	logic [10:0] frame_number;
	logic next_token_valid, next_any_frame, next_irq_enable, next_pin_disable;
	logic [10:0] next_frame_number;
	logic [6:0] next_function_address;
	logic [7:0] next_rdata;
	logic frame_start, frame_set, status_wr, ram_wr;
	logic [1:0] ep;

	assign ep = endpoint_select_in;
	assign frame_start = sof_token_in | artificial_sof_in;
	assign status_wr = sfr_wr_in && sfr_addr_in == usb_tx_pkg::FRAME_STATUS_HIGH_ADDR;
	// software one acts like a hardware set
	assign frame_set = frame_start | (status_wr & sfr_wdata_in[usb_tx_pkg::ANY_FRAME_BIT]);
	// data writes ignored with both sets held
	assign ram_wr = sfr_wr_in && sfr_addr_in == usb_tx_pkg::TX_FIFO_DATA_PORT_ADDR
		&& sets[ep] != usb_tx_pkg::SETS_FULL;

	// selected endpoint byte at write pointer
	tx_byte_ram u_ram
	(
		.clk_in(clk_in),
		.wr_en_in(ram_wr),
		.wr_addr_in({ep, wr_ptr[ep]}),
		.wr_data_in(sfr_wdata_in),
		.rd_addr_in({sie_endpoint_in, rd_ptr[sie_endpoint_in]}),
		.rd_data_out(sie_rd_data_out)
	);

	frame_pin_stretch u_pin
	(
		.clk_in(clk_in),
		.rst_in(rst_in),
		.trigger_in(frame_set),
		.flag_in(any_frame),
		.disable_in(pin_disable),
		.frame_pin_n_out(frame_pin_n_out)
	);

	// FIFO bookkeeping for all endpoints
	always_comb
	begin
		logic [9:0] mask;
		logic sel;
		logic mine;
		logic wr_ok;
		mask = usb_tx_pkg::SMALL_PTR_MASK;
		sel = 1'b0;
		mine = 1'b0;
		wr_ok = 1'b0;
		next_ack = tx_acknowledged_out;
		next_err = tx_error_flag_out;
		for (int e = 0; e < 4; e++)
		begin
			next_wr_ptr[e] = wr_ptr[e];
			next_rd_ptr[e] = rd_ptr[e];
			next_rd_mark[e] = rd_mark[e];
			next_cnt[e][0] = cnt[e][0];
			next_cnt[e][1] = cnt[e][1];
			next_sets[e] = sets[e];
			next_rw_idx[e] = rw_idx[e];
			next_rd_set[e] = rd_set[e];
			next_iso_pend[e] = iso_pend[e];
			next_iso_ack[e] = iso_ack[e];
			next_iso_err[e] = iso_err[e];
			mask = (2'(e) == usb_tx_pkg::BIG_ENDPOINT) ? usb_tx_pkg::BIG_PTR_MASK
				: usb_tx_pkg::SMALL_PTR_MASK;
			sel = (2'(e) == ep);
			mine = (2'(e) == sie_endpoint_in);
			wr_ok = sel && sfr_wr_in && sets[e] != usb_tx_pkg::SETS_FULL;
			if (wr_ok && sfr_addr_in == usb_tx_pkg::TX_FIFO_DATA_PORT_ADDR)
			begin
				next_wr_ptr[e] = usb_tx_pkg::ptr_step(wr_ptr[e], mask);
			end
			// high byte leaves index bits alone
			if (wr_ok && sfr_addr_in == usb_tx_pkg::TX_COUNT_HIGH_ADDR
				&& 2'(e) == usb_tx_pkg::BIG_ENDPOINT)
			begin
				next_cnt[e][rw_idx[e]][9:8] = sfr_wdata_in[1:0];
			end
			if (wr_ok && sfr_addr_in == usb_tx_pkg::TX_COUNT_LOW_ADDR)
			begin
				next_cnt[e][rw_idx[e]][7:0] = sfr_wdata_in & mask[7:0];
				next_sets[e] = usb_tx_pkg::fill_next_set(sets[e]);
				next_rw_idx[e] = ~rw_idx[e];
			end
			if (mine && sie_rd_in)
			begin
				next_rd_ptr[e] = usb_tx_pkg::ptr_step(rd_ptr[e], mask);
			end
			// manual moves only outside auto mode
			if (sel && !auto_tx_management_in[e])
			begin
				if (marker_advance_ctl_in)
				begin
					next_rd_mark[e] = rd_ptr[e];
				end
				if (pointer_reverse_ctl_in)
				begin
					next_rd_ptr[e] = rd_mark[e];
				end
			end
			// frame start first, same-cycle done wins
			if (frame_start && iso_pend[e])
			begin
				next_sets[e][rd_set[e]] = 1'b0;
				next_rd_set[e] = ~rd_set[e];
				next_iso_pend[e] = 1'b0;
			end
			if (frame_start && tx_isochronous_flag_in[e])
			begin
				next_ack[e] = iso_ack[e];
				next_err[e] = iso_err[e];
				next_iso_ack[e] = 1'b0;
				next_iso_err[e] = 1'b0;
			end
			// no outcome reported means no action
			if (mine && sie_done_in && (tx_ack_in || tx_err_in))
			begin
				if (tx_isochronous_flag_in[e])
				begin
					next_iso_ack[e] = tx_ack_in;
					next_iso_err[e] = tx_err_in & ~tx_ack_in;
				end
				else
				begin
					next_ack[e] = tx_ack_in;
					next_err[e] = tx_err_in & ~tx_ack_in;
				end
				if (auto_tx_management_in[e])
				begin
					if (tx_isochronous_flag_in[e])
					begin
						next_rd_mark[e] = rd_ptr[e];
						next_iso_pend[e] = 1'b1;
					end
					else if (tx_ack_in)
					begin
						next_rd_mark[e] = rd_ptr[e];
						next_sets[e][rd_set[e]] = 1'b0;
						next_rd_set[e] = ~rd_set[e];
					end
					else
					begin
						next_rd_ptr[e] = rd_mark[e];
					end
				end
			end
		end
	end

	// Frame status, address and read data
	always_comb
	begin
		next_token_valid = token_valid;
		next_frame_number = frame_number;
		next_irq_enable = irq_enable;
		next_pin_disable = pin_disable;
		next_function_address = function_address_out;
		next_any_frame = any_frame;
		if (status_wr)
		begin
			next_any_frame = sfr_wdata_in[usb_tx_pkg::ANY_FRAME_BIT];
			next_irq_enable = sfr_wdata_in[usb_tx_pkg::IRQ_ENABLE_BIT];
			next_pin_disable = sfr_wdata_in[usb_tx_pkg::PIN_DISABLE_BIT];
		end
		if (frame_start)
		begin
			next_any_frame = 1'b1;
		end
		// valid on token, cleared on artificial
		if (sof_token_in)
		begin
			next_token_valid = 1'b1;
			// number kept only from real tokens
			next_frame_number = sof_frame_number_in;
		end
		else if (artificial_sof_in)
		begin
			next_token_valid = 1'b0;
		end
		// seven address bits, top bit dropped
		if (sfr_wr_in && sfr_addr_in == usb_tx_pkg::FUNCTION_ADDRESS_ADDR)
		begin
			next_function_address = sfr_wdata_in[6:0];
		end
		next_rdata = sfr_rdata_out;
		if (sfr_rd_in)
		begin
			case (sfr_addr_in)
				usb_tx_pkg::FUNCTION_ADDRESS_ADDR: next_rdata = {1'b0, function_address_out};
				usb_tx_pkg::FRAME_NUMBER_LOW_ADDR: next_rdata = frame_number[7:0];
				usb_tx_pkg::FRAME_STATUS_HIGH_ADDR: next_rdata = {token_valid, any_frame,
					irq_enable, frame_timer_locked_in, pin_disable, frame_number[10:8]};
				usb_tx_pkg::TX_COUNT_LOW_ADDR: next_rdata = cnt[ep][rw_idx[ep]][7:0];
				usb_tx_pkg::TX_COUNT_HIGH_ADDR: next_rdata = {6'h00, cnt[ep][rw_idx[ep]][9:8]};
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			for (int e = 0; e < 4; e++)
			begin
				wr_ptr[e] <= usb_tx_pkg::PTR_RESET;
				rd_ptr[e] <= usb_tx_pkg::PTR_RESET;
				rd_mark[e] <= usb_tx_pkg::PTR_RESET;
				cnt[e][0] <= usb_tx_pkg::COUNT_RESET;
				cnt[e][1] <= usb_tx_pkg::COUNT_RESET;
				sets[e] <= usb_tx_pkg::SETS_EMPTY;
				rw_idx[e] <= 1'b0;
				rd_set[e] <= 1'b0;
				iso_pend[e] <= 1'b0;
				iso_ack[e] <= 1'b0;
				iso_err[e] <= 1'b0;
			end
			tx_acknowledged_out <= 4'h0;
			tx_error_flag_out <= 4'h0;
			tx_set_index_bits_out <= 8'h00;
			tx_byte_count_out <= usb_tx_pkg::COUNT_RESET;
			token_valid <= 1'b0;
			any_frame <= 1'b0;
			irq_enable <= 1'b0;
			pin_disable <= 1'b0;
			frame_number <= usb_tx_pkg::FRAME_NUMBER_RESET;
			function_address_out <= usb_tx_pkg::FUNCTION_ADDRESS_RESET;
			sfr_rdata_out <= 8'h00;
			frame_irq_out <= 1'b0;
		end
		else
		begin
			for (int e = 0; e < 4; e++)
			begin
				wr_ptr[e] <= next_wr_ptr[e];
				rd_ptr[e] <= next_rd_ptr[e];
				rd_mark[e] <= next_rd_mark[e];
				cnt[e][0] <= next_cnt[e][0];
				cnt[e][1] <= next_cnt[e][1];
				sets[e] <= next_sets[e];
				rw_idx[e] <= next_rw_idx[e];
				rd_set[e] <= next_rd_set[e];
				iso_pend[e] <= next_iso_pend[e];
				iso_ack[e] <= next_iso_ack[e];
				iso_err[e] <= next_iso_err[e];
			end
			tx_acknowledged_out <= next_ack;
			tx_error_flag_out <= next_err;
			tx_set_index_bits_out <= {next_sets[3], next_sets[2], next_sets[1], next_sets[0]};
			tx_byte_count_out <= next_cnt[sie_endpoint_in][next_rd_set[sie_endpoint_in]];
			token_valid <= next_token_valid;
			any_frame <= next_any_frame;
			irq_enable <= next_irq_enable;
			pin_disable <= next_pin_disable;
			frame_number <= next_frame_number;
			function_address_out <= next_function_address;
			sfr_rdata_out <= next_rdata;
			frame_irq_out <= next_any_frame & next_irq_enable;
		end
	end
endmodule : usb_fn_tx_fifo_frame_status
`default_nettype wire

// ### tb/usb_tx_checker.sv
`timescale 1ns/1ps
`default_nettype none
module usb_tx_checker
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Register access
	input wire logic [7:0] sfr_addr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic sfr_wr_in,
	input wire logic sfr_rd_in,
	input wire logic [7:0] sfr_rdata_out,
	input wire logic [1:0] endpoint_select_in,
	input wire logic [3:0] tx_isochronous_flag_in,
	input wire logic [3:0] auto_tx_management_in,
	// Serial engine
	input wire logic [1:0] sie_endpoint_in,
	input wire logic sie_done_in,
	input wire logic tx_ack_in,
	input wire logic tx_err_in,
	input wire logic [3:0] tx_acknowledged_out,
	input wire logic [3:0] tx_error_flag_out,
	input wire logic [7:0] tx_set_index_bits_out,
	// Frame timing
	input wire logic sof_token_in,
	input wire logic [10:0] sof_frame_number_in,
	input wire logic artificial_sof_in,
	input wire logic frame_timer_locked_in,
	input wire logic frame_irq_out,
	input wire logic frame_pin_n_out,
	input wire logic [6:0] function_address_out
);
	logic [10:0] last_num;
	logic [10:0] next_last_num;
	logic token_ok;
	logic next_token_ok;
	logic [1:0] sel_bits;
	logic w_d3;
	logic cw;
	logic quiet;
	logic pin_cause;
	logic irq_cause;
	assign sel_bits = tx_set_index_bits_out[2*endpoint_select_in +: 2];
	assign w_d3 = sfr_wr_in && sfr_addr_in == usb_tx_pkg::FRAME_STATUS_HIGH_ADDR;
	assign cw = sfr_wr_in && sfr_addr_in == usb_tx_pkg::TX_COUNT_LOW_ADDR;
	assign quiet = !sie_done_in && !sof_token_in && !artificial_sof_in;
	assign pin_cause = sof_token_in || artificial_sof_in || (w_d3 && sfr_wdata_in[6]);
	assign irq_cause = sof_token_in || artificial_sof_in || w_d3;
	// Expected frame number and token flag
	always_comb
	begin
		next_last_num = sof_token_in ? sof_frame_number_in : last_num;
		next_token_ok = sof_token_in ? 1'b1 : (artificial_sof_in ? 1'b0 : token_ok);
	end
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			last_num <= 11'h000;
			token_ok <= 1'b0;
		end
		else
		begin
			last_num <= next_last_num;
			token_ok <= next_token_ok;
		end
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	sequence s_pin_pulse;
		(!frame_pin_n_out)[*8] ##1 frame_pin_n_out;
	endsequence
	property p_addr;
		logic [6:0] v;
		(sfr_wr_in && sfr_addr_in == usb_tx_pkg::FUNCTION_ADDRESS_ADDR, v = sfr_wdata_in[6:0])
			|=> function_address_out == v;
	endproperty
	property p_fill;
		logic [1:0] v;
		(cw && quiet && sel_bits != 2'h3, v = sel_bits) ##1 $stable(endpoint_select_in)
			|-> sel_bits == ((v == 2'h0) ? 2'h1 : 2'h3);
	endproperty
	AST_PIN_PULSE: assert property ($fell(frame_pin_n_out) |-> $past(pin_cause) ##0 s_pin_pulse)
		else $error("frame pin pulse wrong");
	AST_IRQ_CAUSE: assert property ($rose(frame_irq_out) |-> $past(irq_cause) || $past(irq_cause, 2))
		else $error("frame irq without cause");
	AST_NUM_LOW: assert property (sfr_rd_in && sfr_addr_in == usb_tx_pkg::FRAME_NUMBER_LOW_ADDR
		|=> sfr_rdata_out == last_num[7:0]) else $error("frame number low wrong");
	AST_STATUS_HIGH: assert property (sfr_rd_in && sfr_addr_in == usb_tx_pkg::FRAME_STATUS_HIGH_ADDR
		|=> sfr_rdata_out[7] == token_ok && sfr_rdata_out[4] == $past(frame_timer_locked_in)
		&& sfr_rdata_out[2:0] == last_num[10:8]) else $error("frame status high wrong");
	AST_ADDR: assert property (p_addr) else $error("function address wrong");
	AST_DATA_WO: assert property (sfr_rd_in && sfr_addr_in == usb_tx_pkg::TX_FIFO_DATA_PORT_ADDR
		|=> sfr_rdata_out == 8'h00) else $error("data port read not zero");
	AST_EXCL: assert property ((tx_acknowledged_out & tx_error_flag_out) == 4'h0)
		else $error("ack and error both set");
	AST_FULL: assert property (cw && quiet && sel_bits == 2'h3 |=> $stable(tx_set_index_bits_out))
		else $error("write to full fifo changed set bits");
	AST_FILL: assert property (p_fill) else $error("set bits after count write wrong");
	AST_IDLE_DONE: assert property (sie_done_in && !sfr_wr_in && !sof_token_in && !artificial_sof_in
		&& ((!tx_ack_in && !tx_err_in) || !auto_tx_management_in[sie_endpoint_in])
		|=> $stable(tx_set_index_bits_out)) else $error("set bits changed without action");
	AST_AUTO_ACK: assert property (sie_done_in && tx_ack_in && !tx_err_in
		&& auto_tx_management_in[sie_endpoint_in] && !tx_isochronous_flag_in[sie_endpoint_in]
		##1 $stable(sie_endpoint_in) |-> tx_acknowledged_out[sie_endpoint_in]
		&& !tx_error_flag_out[sie_endpoint_in]) else $error("ack status missing");
endmodule : usb_tx_checker
bind usb_fn_tx_fifo_frame_status usb_tx_checker usb_tx_checker_i (.*);
`default_nettype wire

// ### tb/usb_sie_model.sv
`timescale 1ns/1ps
`default_nettype none
module usb_sie_model
(
	// Clock and read data
	input wire logic clk_in,
	input wire logic [7:0] rd_data_in,
	// Read side
	output logic [1:0] ep_out,
	output logic rd_out,
	// Transfer outcome
	output logic done_out,
	output logic ack_out,
	output logic err_out,
	// Frame starts
	output logic sof_out,
	output logic [10:0] num_out,
	output logic art_out
);
	initial
	begin
		{ep_out, rd_out, done_out, ack_out, err_out, sof_out, art_out} = 8'h00;
		num_out = 11'h7FF;
	end
	task step;
		@(posedge clk_in);
		#1;
	endtask : step
	task rd_byte(input logic [1:0] ep, output logic [7:0] d);
		step;
		ep_out = ep;
		step;
		step;
		d = rd_data_in;
		rd_out = 1'b1;
		step;
		rd_out = 1'b0;
	endtask : rd_byte
	// one outcome per transfer; levels garbled once released
	task xfer(input logic [1:0] ep, input logic a, input logic e);
		step;
		ep_out = ep;
		ack_out = a;
		err_out = e;
		done_out = 1'b1;
		step;
		done_out = 1'b0;
		ack_out = ~a;
		err_out = ~e;
	endtask : xfer
	task frame(input logic real_sof, input logic [10:0] n);
		step;
		if (real_sof)
		begin
			sof_out = 1'b1;
			num_out = n;
		end
		else
			art_out = 1'b1;
		step;
		sof_out = 1'b0;
		art_out = 1'b0;
		num_out = ~num_out;
	endtask : frame
endmodule : usb_sie_model
`default_nettype wire

// ### tb/tb_usb_fn_tx_fifo_frame_status.sv
`timescale 1ns/1ps
`default_nettype none
module tb_usb_fn_tx_fifo_frame_status;
	logic clk_in, rst_in, sfr_wr_in, sfr_rd_in, marker_advance_ctl_in, pointer_reverse_ctl_in;
	logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out, sie_rd_data_out, tx_set_index_bits_out, d;
	logic [1:0] endpoint_select_in, sie_endpoint_in;
	logic [3:0] tx_isochronous_flag_in, auto_tx_management_in, tx_acknowledged_out, tx_error_flag_out;
	logic sie_rd_in, sie_done_in, tx_ack_in, tx_err_in, sof_token_in, artificial_sof_in;
	logic frame_timer_locked_in, frame_irq_out, frame_pin_n_out;
	logic [10:0] sof_frame_number_in;
	logic [9:0] tx_byte_count_out;
	logic [6:0] function_address_out;
	logic [7:0] ra [6];
	logic [7:0] rv [6];
	int n_errors;
	int checked;
	usb_fn_tx_fifo_frame_status usb_fn_tx_fifo_frame_status_i (.*);
	usb_sie_model usb_sie_model_i (.clk_in(clk_in), .rd_data_in(sie_rd_data_out),
		.ep_out(sie_endpoint_in), .rd_out(sie_rd_in), .done_out(sie_done_in),
		.ack_out(tx_ack_in), .err_out(tx_err_in), .sof_out(sof_token_in),
		.num_out(sof_frame_number_in), .art_out(artificial_sof_in));
	initial
	begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	task tick;
		@(posedge clk_in);
		#1;
	endtask : tick
	task chk(input string name, input logic [10:0] exp, input logic [10:0] got);
		checked++;
		if (got !== exp)
		begin
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
			n_errors++;
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] v);
		tick;
		sfr_addr_in = a;
		sfr_wdata_in = v;
		sfr_wr_in = 1'b1;
		tick;
		sfr_wr_in = 1'b0;
	endtask : wr
	task rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
		tick;
		sfr_addr_in = a;
		sfr_rd_in = 1'b1;
		tick;
		sfr_rd_in = 1'b0;
		chk(name, exp, sfr_rdata_out);
	endtask : rd_chk
	// One byte then its count
	task put(input logic [7:0] b);
		wr(8'hF3, b);
		wr(8'hF6, 8'h01);
	endtask : put
	task finish_test;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test
	initial
	begin
		repeat (5000) @(posedge clk_in);
		n_errors++;
		finish_test;
	end
	initial
	begin
		{rst_in, sfr_wr_in, sfr_rd_in, marker_advance_ctl_in, pointer_reverse_ctl_in} = 5'h10;
		{sfr_addr_in, sfr_wdata_in, endpoint_select_in} = 18'h00000;
		tx_isochronous_flag_in = 4'h8;
		auto_tx_management_in = 4'hB;
		frame_timer_locked_in = 1'b1;
		n_errors = 0;
		checked = 0;
		ra = '{8'h8F, 8'hD2, 8'hD3, 8'hF6, 8'hF3, 8'h00};
		rv = '{8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00};
		repeat (3) @(posedge clk_in);
		#1;
		rst_in = 1'b0;
		for (int i = 0; i < 6; i++)
			rd_chk("reset value", ra[i], rv[i]);
		chk("set bits", 8'h00, tx_set_index_bits_out);
		wr(8'h8F, 8'h35);
		chk("function address", 7'h35, function_address_out);
		rd_chk("function address", 8'h8F, 8'h35);
		wr(8'hD3, 8'h20);
		usb_sie_model_i.frame(1'b1, 11'h5A3);
		repeat (7) tick;
		chk("frame pin", 1'b0, frame_pin_n_out);
		tick;
		chk("frame pin", 1'b1, frame_pin_n_out);
		chk("frame irq", 1'b1, frame_irq_out);
		rd_chk("frame low", 8'hD2, 8'hA3);
		rd_chk("frame high", 8'hD3, 8'hF5);
		wr(8'hD3, 8'h20);
		rd_chk("frame high", 8'hD3, 8'hB5);
		chk("frame irq", 1'b0, frame_irq_out);
		usb_sie_model_i.frame(1'b0, 11'h000);
		repeat (8) tick;
		rd_chk("frame high", 8'hD3, 8'h75);
		rd_chk("frame low", 8'hD2, 8'hA3);
		chk("frame irq", 1'b1, frame_irq_out);
		wr(8'hD3, 8'h28);
		wr(8'hD3, 8'h68);
		repeat (2) tick;
		chk("frame pin", 1'b1, frame_pin_n_out);
		frame_timer_locked_in = 1'b0;
		rd_chk("frame high", 8'hD3, 8'h6D);
		wr(8'hD3, 8'h00);
		endpoint_select_in = 2'h1;
		for (int i = 1; i < 4; i++)
			wr(8'hF3, 8'(8'h11 * i));
		wr(8'hF7, 8'h00);
		wr(8'hF6, 8'h03);
		chk("set bits ep1", 2'h1, tx_set_index_bits_out[3:2]);
		for (int i = 1; i < 4; i++)
		begin
			usb_sie_model_i.rd_byte(2'h1, d);
			chk("fifo byte", 8'(8'h11 * i), d);
		end
		chk("byte count", 10'h003, tx_byte_count_out);
		usb_sie_model_i.xfer(2'h1, 1'b0, 1'b0);
		chk("set bits ep1", 2'h1, tx_set_index_bits_out[3:2]);
		usb_sie_model_i.xfer(2'h1, 1'b1, 1'b0);
		chk("set bits ep1", 2'h0, tx_set_index_bits_out[3:2]);
		chk("ack ep1", 2'h1, {tx_error_flag_out[1], tx_acknowledged_out[1]});
		wr(8'hF3, 8'h44);
		wr(8'hF3, 8'h55);
		wr(8'hF7, 8'h01);
		wr(8'hF6, 8'h02);
		usb_sie_model_i.rd_byte(2'h1, d);
		chk("byte count", 10'h102, tx_byte_count_out);
		usb_sie_model_i.rd_byte(2'h1, d);
		usb_sie_model_i.xfer(2'h1, 1'b0, 1'b1);
		chk("err ep1", 2'h2, {tx_error_flag_out[1], tx_acknowledged_out[1]});
		chk("set bits ep1", 2'h1, tx_set_index_bits_out[3:2]);
		usb_sie_model_i.rd_byte(2'h1, d);
		chk("resent byte", 8'h44, d);
		tick;
		marker_advance_ctl_in = 1'b1;
		pointer_reverse_ctl_in = 1'b1;
		tick;
		marker_advance_ctl_in = 1'b0;
		pointer_reverse_ctl_in = 1'b0;
		usb_sie_model_i.rd_byte(2'h1, d);
		chk("auto ignores manual", 8'h55, d);
		endpoint_select_in = 2'h0;
		put(8'hA1);
		put(8'hA2);
		chk("set bits ep0", 2'h3, tx_set_index_bits_out[1:0]);
		usb_sie_model_i.rd_byte(2'h0, d);
		chk("fifo byte", 8'hA1, d);
		usb_sie_model_i.xfer(2'h0, 1'b1, 1'b0);
		chk("set bits ep0", 2'h2, tx_set_index_bits_out[1:0]);
		put(8'hA3);
		chk("set bits ep0", 2'h3, tx_set_index_bits_out[1:0]);
		put(8'hFF);
		chk("set bits ep0", 2'h3, tx_set_index_bits_out[1:0]);
		usb_sie_model_i.rd_byte(2'h0, d);
		chk("fifo byte", 8'hA2, d);
		usb_sie_model_i.xfer(2'h0, 1'b1, 1'b0);
		usb_sie_model_i.rd_byte(2'h0, d);
		chk("fifo byte", 8'hA3, d);
		usb_sie_model_i.xfer(2'h0, 1'b1, 1'b0);
		put(8'hB4);
		usb_sie_model_i.rd_byte(2'h0, d);
		chk("pointer after ignored write", 8'hB4, d);
		endpoint_select_in = 2'h2;
		put(8'h66);
		usb_sie_model_i.rd_byte(2'h2, d);
		chk("fifo byte", 8'h66, d);
		usb_sie_model_i.xfer(2'h2, 1'b1, 1'b0);
		chk("set bits ep2", 2'h1, tx_set_index_bits_out[5:4]);
		tick;
		pointer_reverse_ctl_in = 1'b1;
		tick;
		pointer_reverse_ctl_in = 1'b0;
		usb_sie_model_i.rd_byte(2'h2, d);
		chk("manual resend", 8'h66, d);
		endpoint_select_in = 2'h3;
		put(8'h77);
		usb_sie_model_i.rd_byte(2'h3, d);
		usb_sie_model_i.xfer(2'h3, 1'b0, 1'b1);
		chk("set bits ep3", 2'h1, tx_set_index_bits_out[7:6]);
		chk("err ep3", 1'b0, tx_error_flag_out[3]);
		usb_sie_model_i.frame(1'b1, 11'h001);
		tick;
		chk("set bits ep3", 2'h0, tx_set_index_bits_out[7:6]);
		chk("err ep3", 1'b1, tx_error_flag_out[3]);
		finish_test;
	end
endmodule : tb_usb_fn_tx_fifo_frame_status
`default_nettype wire
